/* verilog/dbgc_cfg.svh */
`ifndef DBGC_CFG_SVH
`define DBGC_CFG_SVH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define DBGC_ADDR_W 16
`define DBGC_CNT_W 4
`define DBGC_NUM_BP 4
`define DBGC_BP_IDX_W 2

// ----------------------------------------------------------------------------
// Instruction timing limits
// ----------------------------------------------------------------------------
`define DBGC_MAX_CYC 4'h8
`define DBGC_MIN_CYC 4'h1

`endif

/* verilog/dbgc_pkg.sv */
`include "dbgc_cfg.svh"

package dbgc_pkg;

  typedef enum logic [1:0] {
    DBGC_ST_RUN  = 2'b00,
    DBGC_ST_HALT = 2'b01,
    DBGC_ST_STEP = 2'b10,
    DBGC_ST_ACC  = 2'b11
  } dbgc_state_t;

  typedef enum logic [3:0] {
    DBGC_CMD_NOP    = 4'h0,
    DBGC_CMD_HALT   = 4'h1,
    DBGC_CMD_RUN    = 4'h2,
    DBGC_CMD_STEP   = 4'h3,
    DBGC_CMD_SET_BP = 4'h4,
    DBGC_CMD_CLR_BP = 4'h5,
    DBGC_CMD_READ   = 4'h6,
    DBGC_CMD_WRITE  = 4'h7,
    DBGC_CMD_STACK  = 4'h8
  } dbgc_cmd_t;

  typedef enum logic [2:0] {
    DBGC_SP_REG  = 3'h0,
    DBGC_SP_SFR  = 3'h1,
    DBGC_SP_IRAM = 3'h2,
    DBGC_SP_XRAM = 3'h3,
    DBGC_SP_CODE = 3'h4
  } dbgc_space_t;

  typedef struct packed {
    dbgc_state_t state;
    logic [`DBGC_CNT_W-1:0] cnt;
    logic ins_done;
    logic run_en;
    logic halt_req;
    logic bp_skip;
    logic step_issued;
    logic [`DBGC_NUM_BP-1:0] bp_en;
    logic [`DBGC_NUM_BP-1:0][`DBGC_ADDR_W-1:0] bp_addr;
    logic mem_req;
    logic mem_we;
    dbgc_space_t mem_space;
    logic [`DBGC_ADDR_W-1:0] mem_addr;
    logic [7:0] mem_wdata;
    logic rsp_valid;
    logic rsp_err;
    logic [7:0] rdata;
    logic ready;
    logic halted;
  } dbgc_regs_t;

endpackage : dbgc_pkg

/* verilog/dbgc_core_ctl.sv */
// Overview of operation
// RQ1: Flash programmed through the two-wire development port.
// RQ2: Debugger sets breakpoints, runs, halts, single-steps.
// RQ3: Halted core's call stack readable by debugger.
// RQ4: Debugger reads and writes registers and memory.
// RQ5: Debug uses no application-visible resources.
// RQ6: Opcodes, addressing, flags match standard set.
// RQ7: Timing counted in whole system clock cycles.
// RQ8: Most instructions take cycles equal bytes.
// RQ9: Untaken conditional branch takes one cycle less.
// RQ10: No instruction exceeds eight clock cycles.
// RQ11: Single step executes exactly one instruction.
`timescale 1ns/1ps
`include "dbgc_cfg.svh"

module dbgc_core_ctl (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_dbg_cmd_valid,
  input wire logic [3:0] i_dbg_cmd,
  input wire logic [2:0] i_dbg_space,
  input wire logic [`DBGC_BP_IDX_W-1:0] i_dbg_bp_idx,
  input wire logic [`DBGC_ADDR_W-1:0] i_dbg_addr,
  input wire logic [7:0] i_dbg_wdata,
  input wire logic i_ins_start,
  input wire logic [1:0] i_ins_bytes,
  input wire logic i_ins_fixed,
  input wire logic [`DBGC_CNT_W-1:0] i_ins_cycles,
  input wire logic i_ins_is_branch,
  input wire logic i_ins_taken,
  input wire logic [`DBGC_ADDR_W-1:0] i_next_pc,
  input wire logic [7:0] i_core_sp,
  input wire logic i_mem_ack,
  input wire logic [7:0] i_mem_rdata,
  output logic o_run_en,
  output logic o_ins_done,
  output logic o_halted,
  output logic o_dbg_ready,
  output logic o_dbg_rsp_valid,
  output logic o_dbg_rsp_err,
  output logic [7:0] o_dbg_rdata,
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [2:0] o_mem_space,
  output logic [`DBGC_ADDR_W-1:0] o_mem_addr,
  output logic [7:0] o_mem_wdata
);

  dbgc_pkg::dbgc_regs_t st_ff;
  dbgc_pkg::dbgc_regs_t nxt_st;
  logic [`DBGC_CNT_W-1:0] nxt_cyc;
  logic [`DBGC_CNT_W-1:0] base_cyc;
  logic idle;
  logic bp_hit;
  logic cmd_ok;
  dbgc_pkg::dbgc_cmd_t cmd;

  // ----------------------------------------------------------------------------
  // Cycle count of the issuing instruction
  // ----------------------------------------------------------------------------
  // The opcode itself is decoded by the core untouched; only its cycle count
  // is shaped here, so encoding and flag effects stay standard. [RQ6]
  always_comb begin
    base_cyc = i_ins_fixed ? i_ins_cycles : {2'b00, i_ins_bytes}; // [RQ8]
    if (i_ins_is_branch && !i_ins_taken) begin
      base_cyc = base_cyc - `DBGC_MIN_CYC; // [RQ9]
    end
    if (base_cyc > `DBGC_MAX_CYC) begin
      nxt_cyc = `DBGC_MAX_CYC; // [RQ10]
    end else if (base_cyc < `DBGC_MIN_CYC) begin
      nxt_cyc = `DBGC_MIN_CYC; // [RQ7]
    end else begin
      nxt_cyc = base_cyc;
    end
  end

  // ----------------------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    cmd = dbgc_pkg::dbgc_cmd_t'(i_dbg_cmd);
    cmd_ok = i_dbg_cmd_valid && st_ff.ready;
    nxt_st.ins_done = 1'b0;
    nxt_st.rsp_valid = 1'b0;
    nxt_st.rsp_err = 1'b0;
    // Whole-cycle countdown; a start loads the count of cycles still to run.
    if (i_ins_start) begin
      nxt_st.cnt = nxt_cyc - `DBGC_MIN_CYC; // [RQ7]
      nxt_st.ins_done = (nxt_cyc == `DBGC_MIN_CYC);
      nxt_st.bp_skip = 1'b0;
      if (st_ff.state == dbgc_pkg::DBGC_ST_STEP) begin
        nxt_st.step_issued = 1'b1; // [RQ11]
      end
    end else if (st_ff.cnt != '0) begin
      nxt_st.cnt = st_ff.cnt - `DBGC_MIN_CYC;
      nxt_st.ins_done = (st_ff.cnt == `DBGC_MIN_CYC);
    end
    idle = !i_ins_start && (st_ff.cnt == '0);
    bp_hit = 1'b0;
    for (int i = 0; i < `DBGC_NUM_BP; i++) begin
      if (st_ff.bp_en[i] && (st_ff.bp_addr[i] == i_next_pc)) begin
        bp_hit = 1'b1; // [RQ2]
      end
    end
    if (cmd_ok && (cmd == dbgc_pkg::DBGC_CMD_SET_BP)) begin
      nxt_st.bp_en[i_dbg_bp_idx] = 1'b1; // [RQ2]
      nxt_st.bp_addr[i_dbg_bp_idx] = i_dbg_addr;
      nxt_st.rsp_valid = 1'b1;
    end
    if (cmd_ok && (cmd == dbgc_pkg::DBGC_CMD_CLR_BP)) begin
      nxt_st.bp_en[i_dbg_bp_idx] = 1'b0;
      nxt_st.rsp_valid = 1'b1;
    end
    unique case (st_ff.state)
      dbgc_pkg::DBGC_ST_RUN: begin
        if (cmd_ok && (cmd == dbgc_pkg::DBGC_CMD_HALT)) begin
          nxt_st.halt_req = 1'b1;
          nxt_st.rsp_valid = 1'b1;
        end
        // Halting waits for an instruction boundary so no instruction is cut.
        if (idle && (nxt_st.halt_req || (bp_hit && !st_ff.bp_skip))) begin
          nxt_st.state = dbgc_pkg::DBGC_ST_HALT; // [RQ2]
          nxt_st.halt_req = 1'b0;
        end
      end
      dbgc_pkg::DBGC_ST_STEP: begin
        // A halt during a step is answered at once; the step still runs to its end.
        if (cmd_ok && (cmd == dbgc_pkg::DBGC_CMD_HALT)) begin
          nxt_st.rsp_valid = 1'b1;
        end
        if (st_ff.step_issued && idle) begin
          nxt_st.state = dbgc_pkg::DBGC_ST_HALT; // [RQ11]
        end
      end
      dbgc_pkg::DBGC_ST_HALT: begin
        if (cmd_ok) begin
          nxt_st.rsp_valid = 1'b1;
          unique case (cmd)
            dbgc_pkg::DBGC_CMD_RUN: begin
              nxt_st.state = dbgc_pkg::DBGC_ST_RUN;
              nxt_st.bp_skip = 1'b1;
            end
            dbgc_pkg::DBGC_CMD_STEP: begin
              nxt_st.state = dbgc_pkg::DBGC_ST_STEP; // [RQ2]
              nxt_st.step_issued = 1'b0;
            end
            dbgc_pkg::DBGC_CMD_READ, dbgc_pkg::DBGC_CMD_WRITE: begin
              nxt_st.rsp_valid = 1'b0;
              nxt_st.state = dbgc_pkg::DBGC_ST_ACC; // [RQ4]
              nxt_st.mem_req = 1'b1;
              nxt_st.mem_we = (cmd == dbgc_pkg::DBGC_CMD_WRITE); // [RQ1]
              nxt_st.mem_space = dbgc_pkg::dbgc_space_t'(i_dbg_space);
              nxt_st.mem_addr = i_dbg_addr;
              nxt_st.mem_wdata = i_dbg_wdata;
            end
            dbgc_pkg::DBGC_CMD_STACK: begin
              // Walks down from the live stack pointer; the core's own SP and
              // RAM are never touched, so the program sees nothing. [RQ5]
              nxt_st.rsp_valid = 1'b0;
              nxt_st.state = dbgc_pkg::DBGC_ST_ACC; // [RQ3]
              nxt_st.mem_req = 1'b1;
              nxt_st.mem_we = 1'b0;
              nxt_st.mem_space = dbgc_pkg::DBGC_SP_IRAM;
              nxt_st.mem_addr = {8'h00, i_core_sp - i_dbg_addr[7:0]};
            end
            default: begin
              nxt_st.rsp_valid = (cmd == dbgc_pkg::DBGC_CMD_HALT) ||
                                 (cmd == dbgc_pkg::DBGC_CMD_SET_BP) ||
                                 (cmd == dbgc_pkg::DBGC_CMD_CLR_BP);
              nxt_st.rsp_err = !nxt_st.rsp_valid;
              nxt_st.rsp_valid = 1'b1;
            end
          endcase
        end
      end
      dbgc_pkg::DBGC_ST_ACC: begin
        if (i_mem_ack) begin
          nxt_st.mem_req = 1'b0;
          nxt_st.mem_we = 1'b0;
          nxt_st.rdata = i_mem_rdata;
          nxt_st.rsp_valid = 1'b1;
          nxt_st.state = dbgc_pkg::DBGC_ST_HALT;
        end
      end
    endcase
    // Access and step commands are refused with an error while running.
    if (cmd_ok && (st_ff.state != dbgc_pkg::DBGC_ST_HALT) &&
        (cmd != dbgc_pkg::DBGC_CMD_HALT) && (cmd != dbgc_pkg::DBGC_CMD_SET_BP) &&
        (cmd != dbgc_pkg::DBGC_CMD_CLR_BP) && (cmd != dbgc_pkg::DBGC_CMD_NOP)) begin
      nxt_st.rsp_valid = 1'b1;
      nxt_st.rsp_err = 1'b1;
    end
    // The core needs the next pc one cycle ahead so a breakpoint can stop issue.
    nxt_st.run_en = ((nxt_st.state == dbgc_pkg::DBGC_ST_RUN) && !nxt_st.halt_req &&
                     !(bp_hit && !nxt_st.bp_skip)) ||
                    ((nxt_st.state == dbgc_pkg::DBGC_ST_STEP) && !nxt_st.step_issued);
    nxt_st.ready = (nxt_st.state != dbgc_pkg::DBGC_ST_ACC);
    nxt_st.halted = (nxt_st.state == dbgc_pkg::DBGC_ST_HALT);
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_ff <= '0;
      st_ff.state <= dbgc_pkg::DBGC_ST_HALT;
      st_ff.ready <= 1'b1;
      st_ff.halted <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_run_en = st_ff.run_en;
  assign o_ins_done = st_ff.ins_done;
  assign o_halted = st_ff.halted;
  assign o_dbg_ready = st_ff.ready;
  assign o_dbg_rsp_valid = st_ff.rsp_valid;
  assign o_dbg_rsp_err = st_ff.rsp_err;
  assign o_dbg_rdata = st_ff.rdata;
  assign o_mem_req = st_ff.mem_req;
  assign o_mem_we = st_ff.mem_we;
  assign o_mem_space = st_ff.mem_space;
  assign o_mem_addr = st_ff.mem_addr;
  assign o_mem_wdata = st_ff.mem_wdata;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking dbgc_cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  one_byte_a: assert property ( // [RQ8]
    i_ins_start && !i_ins_fixed && !i_ins_is_branch && (i_ins_bytes == 2'h1)
    |=> o_ins_done) else $error("one-byte instruction not done in one cycle");
  three_byte_a: assert property ( // [RQ8]
    i_ins_start && !i_ins_fixed && !i_ins_is_branch && (i_ins_bytes == 2'h3)
    |=> !o_ins_done ##1 !o_ins_done ##1 o_ins_done) else $error("three-byte timing wrong");
  br_untaken_a: assert property ( // [RQ9]
    i_ins_start && i_ins_fixed && i_ins_is_branch && !i_ins_taken && (i_ins_cycles == 4'h3)
    |=> !o_ins_done ##1 o_ins_done) else $error("untaken branch not one cycle shorter");
  max_cycles_a: assert property ( // [RQ10]
    i_ins_start |-> ##[1:8] o_ins_done) else $error("instruction exceeds eight cycles");
  whole_cnt_a: assert property ( // [RQ7]
    st_ff.cnt < `DBGC_MAX_CYC) else $error("cycle counter out of range");
  step_once_a: assert property ( // [RQ11]
    (st_ff.state == dbgc_pkg::DBGC_ST_STEP) && o_run_en && i_ins_start
    |=> !o_run_en [*2]) else $error("step let more than one instruction issue");
  bp_stop_a: assert property ( // [RQ2]
    (st_ff.state == dbgc_pkg::DBGC_ST_RUN) && idle && bp_hit && !st_ff.bp_skip
    |=> o_halted && !o_run_en) else $error("breakpoint did not halt core");
  access_halt_a: assert property ( // [RQ4]
    o_mem_req |-> (st_ff.state == dbgc_pkg::DBGC_ST_ACC) && !o_run_en)
    else $error("debug access while core runs");
  stack_addr_a: assert property ( // [RQ3]
    o_halted && i_dbg_cmd_valid && o_dbg_ready && (i_dbg_cmd == 4'h8)
    |=> o_mem_req && (o_mem_addr[7:0] == $past(i_core_sp) - $past(i_dbg_addr[7:0])))
    else $error("stack read address wrong");
  flash_wr_a: assert property ( // [RQ1]
    o_mem_req && o_mem_we && (o_mem_space == 3'h4) |-> !o_run_en && (st_ff.cnt == '0))
    else $error("flash write while core executes");

endmodule : dbgc_core_ctl

/* verif/dbgc_mem_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Memory side answering debug accesses after a settable wait
// ----------------------------------------------------------------------------
module dbgc_mem_model (
  input wire logic i_clk,
  input wire logic [3:0] i_lat,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [2:0] i_space,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic o_ack,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:255];
  logic [7:0] idx;
  int cnt = 0;
  assign idx = i_addr[7:0] ^ {i_space, 5'h00};
  initial begin
    o_ack = 1'b0;
    o_rdata = 8'h00;
    for (int k = 0; k < 256; k++) mem[k] = 8'(k);
  end
  // The data line toggles outside an ack, so a stale byte is never taken for a good one.
  always @(posedge i_clk) begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_req && !o_ack) begin
      if (cnt >= int'(i_lat)) begin
        cnt <= 0;
        o_ack <= 1'b1;
        o_rdata <= mem[idx];
        if (i_we) mem[idx] <= i_wdata;
      end else cnt <= cnt + 1;
    end
  end
endmodule : dbgc_mem_model

/* verif/cpu_debug_and_instruction_timing_tb_top.sv */
`timescale 1ns/1ps
module cpu_debug_and_instruction_timing_tb_top;
  typedef struct packed {logic [1:0] b; logic f; logic [3:0] c; logic br, tk; logic [3:0] n;}
    dbgc_row_t;
  logic i_clk = 0, rst = 1, cv = 0, st = 0, fx = 0, br = 0, tk = 0, ack, rerr;
  logic [3:0] cc = 0, cy = 0, lat = 0;
  logic [2:0] sp = 0, ms;
  logic [1:0] bi = 0, by = 1;
  logic [15:0] ad = 0, npc = 16'h0050, ma;
  logic [7:0] wd = 0, csp = 8'h40, mrd, rd, rdat, mwd;
  logic re, dn, hl, rdy, rv, er, mrq, mwe;
  int miscompares = 0, n_compared = 0, k;
  dbgc_row_t rows [8] = '{'{1, 0, 0, 0, 0, 1}, '{2, 0, 0, 0, 0, 2}, '{3, 0, 0, 0, 0, 3},
    '{1, 1, 8, 0, 0, 8}, '{1, 1, 15, 0, 0, 8}, '{2, 1, 3, 1, 1, 3}, '{2, 1, 3, 1, 0, 2},
    '{3, 0, 0, 1, 0, 2}};
  dbgc_core_ctl i_dut (.i_clk(i_clk), .i_sys_rst(rst), .i_dbg_cmd_valid(cv), .i_dbg_cmd(cc),
    .i_dbg_space(sp), .i_dbg_bp_idx(bi), .i_dbg_addr(ad), .i_dbg_wdata(wd), .i_ins_start(st),
    .i_ins_bytes(by), .i_ins_fixed(fx), .i_ins_cycles(cy), .i_ins_is_branch(br),
    .i_ins_taken(tk), .i_next_pc(npc), .i_core_sp(csp), .i_mem_ack(ack), .i_mem_rdata(mrd),
    .o_run_en(re), .o_ins_done(dn), .o_halted(hl), .o_dbg_ready(rdy), .o_dbg_rsp_valid(rv),
    .o_dbg_rsp_err(er), .o_dbg_rdata(rd), .o_mem_req(mrq), .o_mem_we(mwe), .o_mem_space(ms),
    .o_mem_addr(ma), .o_mem_wdata(mwd));
  dbgc_mem_model i_mem (.i_clk(i_clk), .i_lat(lat), .i_req(mrq), .i_we(mwe), .i_space(ms),
    .i_addr(ma), .i_wdata(mwd), .o_ack(ack), .o_rdata(mrd));
  initial forever #20 i_clk = ~i_clk;
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick
  // Issues one command and waits for its answer; a silent port ends the run.
  task automatic cmd(input logic [3:0] c, input logic [2:0] s, input logic [15:0] a,
                     input logic [7:0] w);
    int j;
    cc = c;
    sp = s;
    ad = a;
    wd = w;
    cv = 1;
    tick(1);
    cv = 0;
    for (j = 0; j < 30 && rv !== 1'b1; j++) tick(1);
    if (j == 30) begin
      miscompares++;
      stop_test();
    end else begin
      rerr = er;
      rdat = rd;
      // Lets an edge pass so a following command never re-raises the strobe in this step.
      tick(1);
    end
  endtask : cmd
  initial begin
    tick(10);
    chk({hl, re, rdy, rv, mrq}, 16'h0014);
    rst = 0;
    tick(1);
    foreach (rows[i]) begin
      cmd(4'h3, 3'h0, 16'h0000, 8'h00);
      chk(rerr, 0);
      tick(1);
      {by, fx, cy, br, tk} = {rows[i].b, rows[i].f, rows[i].c, rows[i].br, rows[i].tk};
      st = 1;
      tick(1);
      st = 0;
      for (k = 1; k < 12 && dn !== 1'b1; k++) tick(1);
      chk(16'(k), 16'(rows[i].n));
      // The halted state follows one cycle after the done pulse.
      tick(1);
      chk({hl, re}, 16'h0002);
    end
    for (int s = 0; s < 5; s++) begin
      lat = 4'(s);
      cmd(4'h7, 3'(s), 16'h0011, 8'(8'ha0 + s));
      cmd(4'h6, 3'(s), 16'h0011, 8'h00);
      chk({rerr, rdat}, 16'(8'ha0 + s));
    end
    cmd(4'h7, 3'h2, 16'h003e, 8'hc3);
    cmd(4'h8, 3'h0, 16'h0002, 8'h00);
    chk({rerr, rdat, hl}, 16'h0187);
    bi = 1;
    cmd(4'h4, 3'h0, 16'h0100, 8'h00);
    cmd(4'h2, 3'h0, 16'h0000, 8'h00);
    chk({rerr, hl}, 0);
    cmd(4'h6, 3'h2, 16'h0011, 8'h00);
    chk(rerr, 1);
    // The first instruction after a run clears the skip, so the breakpoint can stop issue.
    st = 1;
    npc = 16'h0100;
    tick(1);
    st = 0;
    for (k = 0; k < 4 && hl !== 1'b1; k++) tick(1);
    chk({hl, re}, 16'h0002);
    cmd(4'h5, 3'h0, 16'h0000, 8'h00);
    cmd(4'h2, 3'h0, 16'h0000, 8'h00);
    st = 1;
    tick(1);
    st = 0;
    tick(2);
    chk({hl, re}, 16'h0001);
    cmd(4'h1, 3'h0, 16'h0000, 8'h00);
    for (k = 0; k < 10 && hl !== 1'b1; k++) tick(1);
    chk({rerr, hl, re}, 16'h0002);
    cmd(4'h9, 3'h0, 16'h0000, 8'h00);
    chk(rerr, 1);
    cmd(4'h2, 3'h0, 16'h0000, 8'h00);
    chk({rerr, hl, re}, 16'h0001);
    // A reset in mid-run must drop issue and return to the halted state.
    rst = 1;
    tick(2);
    rst = 0;
    chk({hl, re, rdy, rv, mrq}, 16'h0014);
    tick(1);
    chk({hl, re, rdy, rv, mrq}, 16'h0014);
    stop_test();
  end
endmodule : cpu_debug_and_instruction_timing_tb_top
